// file: rtl/tssic_ctrl.sv
// Behaviour
// - handheld start ignored unless control source is the remote option.
// - handheld start/stop act like panel start/stop buttons, but only with remote source selected.
// - remote source selected: only handheld may start, panel start rejected.
// - panel stop always stops a running test, any source.
// - panel source selected gives start/stop back to the panel.
// - port start/stop inputs act only when signal-port source selected.
// - port stop held 1ms puts device into ready state.
// - port start held 1ms begins a test from ready.
// - port stop during a running test ends the test.
// - interlock on: start refused unless both loop pins are closed.
// - interlock off: loop pins ignored for start decision.
// - five status outputs report the test state.
// - pass, fail, total counts plus per-function pass and fail counts.
// - statistics clear zeroes all counters; counting resumes from zero.
// - blocked start with open loop raises interlock-open flag.
// - each status output selects ready, test, pass, fail, fail-hi, fail-lo.
// - test output held over all steps or pulsed per step.
// - pass/fail outputs report at final step or after each step.
//
// The implementer's own choices: the APB slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module tssic_ctrl #(
  parameter int unsigned HOLD = tssic_pkg::HOLD_CYC
) (
  input  wire logic                        pclk,
  input  wire logic                        presetn,
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [7:0]                  paddr,
  input  wire logic [31:0]                 pwdata,
  output logic      [31:0]                 prdata,
  output logic                             pready,
  output logic                             pslverr,
  input  wire logic                        handheld_go_line,
  input  wire logic                        handheld_halt_line,
  input  wire logic                        port_start_line,
  input  wire logic                        port_stop_line,
  input  wire logic                        safety_loop_a,
  input  wire logic                        safety_loop_b,
  input  wire logic                        step_done,
  input  wire logic                        test_done,
  input  wire logic                        verdict_pass,
  input  wire logic                        verdict_fail_hi,
  input  wire logic                        verdict_fail_lo,
  input  wire logic [tssic_pkg::FUNC_W-1:0] test_func,
  output logic                             test_begin,
  output logic                             test_abort,
  output logic      [tssic_pkg::NOUT-1:0]  status_out
);
  import tssic_pkg::*;

  localparam int unsigned NIN = 5;
  localparam int unsigned DW  = $clog2(HOLD + 1);

  logic [4:0]          ctrl_r;
  logic [14:0]         pinsel_r;
  logic [FUNC_W-1:0]   fsel_r;
  logic                ilk_open_r;
  tssic_state_t        state_r;
  logic [CNT_W-1:0]    pass_cnt_r, fail_cnt_r, total_cnt_r;
  logic [CNT_W-1:0]    fpass_r [NFUNC];
  logic [CNT_W-1:0]    ffail_r [NFUNC];
  logic                v_pass_r, v_fail_r, v_fh_r, v_fl_r;
  logic                step_gap_r;
  logic [31:0]         prdata_r;
  logic                pslverr_r;

  // contact inputs: sync, debounce, rising edge -> request
  logic [NIN-1:0] raw, meta_r, sync_r, deb_r, deb_d_r, req;
  assign raw = {safety_loop_a & safety_loop_b, port_stop_line,
                port_start_line, handheld_halt_line, handheld_go_line};

  genvar gi;
  generate
    for (gi = 0; gi < NIN; gi++) begin : g_in
      logic [DW-1:0] cnt_r;
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          meta_r[gi] <= 1'b0;
          sync_r[gi] <= 1'b0;
        end else begin
          meta_r[gi] <= raw[gi];
          sync_r[gi] <= meta_r[gi];
        end
      end
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          cnt_r      <= '0;
          deb_r[gi]  <= 1'b0;
          deb_d_r[gi] <= 1'b0;
        end else begin
          deb_d_r[gi] <= deb_r[gi];
          if (sync_r[gi] == deb_r[gi]) begin
            cnt_r <= '0;
          end else if (cnt_r == DW'(HOLD - 1)) begin
            cnt_r     <= '0;
            deb_r[gi] <= sync_r[gi];
          end else begin
            cnt_r <= cnt_r + 1'b1;
          end
        end
      end
      assign req[gi] = deb_r[gi] & ~deb_d_r[gi];
    end
  endgenerate

  // apb decode
  logic wr_en, rd_set, hit;
  assign wr_en  = psel & penable & pwrite;
  assign rd_set = psel & ~penable;
  assign pready = 1'b1;
  assign hit = (paddr == OFS_CTRL)  || (paddr == OFS_PINSEL) ||
               (paddr == OFS_CMD)   || (paddr == OFS_STATUS) ||
               (paddr == OFS_PASS)  || (paddr == OFS_FAIL)   ||
               (paddr == OFS_TOTAL) || (paddr == OFS_FSEL)   ||
               (paddr == OFS_FPASS) || (paddr == OFS_FFAIL);

  logic cmd_wr, sw_start, sw_stop, stat_clr, ilk_clr;
  assign cmd_wr   = wr_en & (paddr == OFS_CMD);
  assign sw_start = cmd_wr & pwdata[CMD_START_BIT];
  assign sw_stop  = cmd_wr & pwdata[CMD_STOP_BIT];
  assign stat_clr = cmd_wr & pwdata[CMD_CLR_BIT];
  assign ilk_clr  = cmd_wr & pwdata[CMD_ILKCLR_BIT];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r   <= CTRL_RST;
      pinsel_r <= PINSEL_RST;
      fsel_r   <= '0;
    end else if (wr_en) begin
      if (paddr == OFS_CTRL) begin
        ctrl_r <= pwdata[4:0];
      end else if (paddr == OFS_PINSEL) begin
        pinsel_r <= pwdata[14:0];
      end else if (paddr == OFS_FSEL) begin
        fsel_r <= pwdata[FUNC_W-1:0];
      end
    end
  end

  // start/stop arbitration
  tssic_src_t src;
  logic ilk_on, start_any, stop_any, loop_ok, start_ok;
  assign src    = tssic_src_t'(ctrl_r[CTRL_SRC_LSB +: 2]);
  assign ilk_on = ctrl_r[CTRL_ILK_BIT];
  // panel start only with panel source; handheld acts as panel keys
  assign start_any = ((src == SRC_PANEL)  & sw_start) |
                     ((src == SRC_REMOTE) & req[0]) |
                     ((src == SRC_SIGIO)  & req[2]);
  assign stop_any  = sw_stop |
                     ((src == SRC_REMOTE) & req[1]) |
                     ((src == SRC_SIGIO)  & req[3]);
  assign loop_ok  = ~ilk_on | deb_r[4];
  assign start_ok = start_any & ~stop_any & loop_ok;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r    <= ST_STOP;
      test_begin <= 1'b0;
      test_abort <= 1'b0;
    end else begin
      test_begin <= 1'b0;
      test_abort <= 1'b0;
      case (state_r)
        ST_STOP: begin
          if (stop_any) begin
            state_r <= ST_READY;
          end
        end
        ST_READY: begin
          if (start_ok) begin
            state_r    <= ST_RUN;
            test_begin <= 1'b1;
          end
        end
        ST_RUN: begin
          if (stop_any) begin
            state_r    <= ST_READY;
            test_abort <= 1'b1;
          end else if (test_done) begin
            state_r <= ST_READY;
          end
        end
        default: state_r <= ST_STOP;
      endcase
    end
  end

  // sticky interlock-open flag, set wins over clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ilk_open_r <= 1'b0;
    end else if (state_r == ST_READY && start_any && !stop_any &&
                 !loop_ok) begin
      ilk_open_r <= 1'b1;
    end else if (ilk_clr) begin
      ilk_open_r <= 1'b0;
    end
  end

  // verdict latches and test-pin step gap
  logic verdict_ev;
  assign verdict_ev = test_done |
                      (step_done & ctrl_r[CTRL_PFSTEP_BIT]);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      v_pass_r   <= 1'b0;
      v_fail_r   <= 1'b0;
      v_fh_r     <= 1'b0;
      v_fl_r     <= 1'b0;
      step_gap_r <= 1'b0;
    end else begin
      step_gap_r <= step_done & ctrl_r[CTRL_TSTEP_BIT];
      if (state_r == ST_READY && start_ok) begin
        v_pass_r <= 1'b0;
        v_fail_r <= 1'b0;
        v_fh_r   <= 1'b0;
        v_fl_r   <= 1'b0;
      end else if (state_r == ST_RUN && verdict_ev) begin
        v_pass_r <= verdict_pass;
        v_fail_r <= ~verdict_pass;
        v_fh_r   <= ~verdict_pass & verdict_fail_hi;
        v_fl_r   <= ~verdict_pass & verdict_fail_lo;
      end
    end
  end

  // status pins, each picks its meaning
  // codes 6 and 7 land on the two zero bits on top
  logic [7:0] meaning;
  assign meaning = {2'b00, v_fl_r, v_fh_r, v_fail_r, v_pass_r,
                    (state_r == ST_RUN) & ~step_gap_r,
                    state_r == ST_READY};
  generate
    for (gi = 0; gi < NOUT; gi++) begin : g_out
      logic [PSEL_W-1:0] sel;
      assign sel = pinsel_r[gi*PSEL_W +: PSEL_W];
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          status_out[gi] <= 1'b0;
        end else begin
          status_out[gi] <= meaning[sel];
        end
      end
    end
  endgenerate

  // statistics
  logic count_ev;
  assign count_ev = (state_r == ST_RUN) & test_done & ~stop_any;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pass_cnt_r  <= '0;
      fail_cnt_r  <= '0;
      total_cnt_r <= '0;
    end else if (stat_clr) begin
      pass_cnt_r  <= '0;
      fail_cnt_r  <= '0;
      total_cnt_r <= '0;
    end else if (count_ev) begin
      total_cnt_r <= total_cnt_r + 1'b1;
      if (verdict_pass) begin
        pass_cnt_r <= pass_cnt_r + 1'b1;
      end else begin
        fail_cnt_r <= fail_cnt_r + 1'b1;
      end
    end
  end

  generate
    for (gi = 0; gi < NFUNC; gi++) begin : g_fn
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          fpass_r[gi] <= '0;
          ffail_r[gi] <= '0;
        end else if (stat_clr) begin
          fpass_r[gi] <= '0;
          ffail_r[gi] <= '0;
        end else if (count_ev && test_func == FUNC_W'(gi)) begin
          if (verdict_pass) begin
            fpass_r[gi] <= fpass_r[gi] + 1'b1;
          end else begin
            ffail_r[gi] <= ffail_r[gi] + 1'b1;
          end
        end
      end
    end
  endgenerate

  // read data captured in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r  <= '0;
      pslverr_r <= 1'b0;
    end else if (rd_set) begin
      pslverr_r <= ~hit;
      if (pwrite) begin
        prdata_r <= '0;
      end else if (paddr == OFS_CTRL) begin
        prdata_r <= {27'h0, ctrl_r};
      end else if (paddr == OFS_PINSEL) begin
        prdata_r <= {17'h0, pinsel_r};
      end else if (paddr == OFS_STATUS) begin
        prdata_r <= {26'h0, deb_r[4], ilk_open_r, 1'b0, state_r};
      end else if (paddr == OFS_PASS) begin
        prdata_r <= pass_cnt_r;
      end else if (paddr == OFS_FAIL) begin
        prdata_r <= fail_cnt_r;
      end else if (paddr == OFS_TOTAL) begin
        prdata_r <= total_cnt_r;
      end else if (paddr == OFS_FSEL) begin
        prdata_r <= {{(32-FUNC_W){1'b0}}, fsel_r};
      end else if (paddr == OFS_FPASS) begin
        prdata_r <= fpass_r[fsel_r];
      end else if (paddr == OFS_FFAIL) begin
        prdata_r <= ffail_r[fsel_r];
      end else begin
        prdata_r <= '0;
      end
    end
  end
  assign prdata  = prdata_r;
  assign pslverr = pslverr_r & psel & penable;
endmodule : tssic_ctrl
`default_nettype wire

// file: common/tssic_pkg.sv
package tssic_pkg;
  localparam int unsigned PCLK_HZ        = 200_000_000;
  localparam int unsigned HOLD_US        = 1000; // least closure: 1ms
  localparam int unsigned HOLD_CYC       = (PCLK_HZ / 1_000_000) * HOLD_US;
  localparam int unsigned CNT_W          = 32;
  localparam int unsigned NFUNC          = 8;
  localparam int unsigned FUNC_W         = 3;
  localparam int unsigned NOUT           = 5;
  // register byte offsets
  localparam logic [7:0] OFS_CTRL        = 8'h00;
  localparam logic [7:0] OFS_PINSEL      = 8'h04;
  localparam logic [7:0] OFS_CMD         = 8'h08;
  localparam logic [7:0] OFS_STATUS      = 8'h0c;
  localparam logic [7:0] OFS_PASS        = 8'h10;
  localparam logic [7:0] OFS_FAIL        = 8'h14;
  localparam logic [7:0] OFS_TOTAL       = 8'h18;
  localparam logic [7:0] OFS_FSEL        = 8'h1c;
  localparam logic [7:0] OFS_FPASS       = 8'h20;
  localparam logic [7:0] OFS_FFAIL       = 8'h24;
  // ctrl fields
  localparam int unsigned CTRL_SRC_LSB   = 0;  // 2 bits
  localparam int unsigned CTRL_ILK_BIT   = 2;
  localparam int unsigned CTRL_TSTEP_BIT = 3;
  localparam int unsigned CTRL_PFSTEP_BIT= 4;
  localparam logic [4:0]  CTRL_RST       = 5'h00;
  // cmd fields (write one to act)
  localparam int unsigned CMD_START_BIT  = 0;
  localparam int unsigned CMD_STOP_BIT   = 1;
  localparam int unsigned CMD_CLR_BIT    = 2;
  localparam int unsigned CMD_ILKCLR_BIT = 3;
  // pinsel: 3 bits per output pin
  localparam int unsigned PSEL_W         = 3;
  localparam logic [14:0] PINSEL_RST     = 15'h4688; // pins 1..5: 0..4
  typedef enum logic [1:0] {
    SRC_PANEL  = 2'h0,
    SRC_REMOTE = 2'h1,
    SRC_SIGIO  = 2'h2
  } tssic_src_t;
  typedef enum logic [2:0] {
    OUT_READY = 3'h0, OUT_TEST = 3'h1, OUT_PASS = 3'h2,
    OUT_FAIL  = 3'h3, OUT_FAILH = 3'h4, OUT_FAILL = 3'h5
  } tssic_omode_t;
  typedef enum logic [2:0] {
    ST_STOP  = 3'b001,
    ST_READY = 3'b010,
    ST_RUN   = 3'b100
  } tssic_state_t;
endpackage : tssic_pkg

// file: verif/tssic_fixture.sv
`timescale 1ns/1ps
`default_nettype none
module tssic_fixture #(
  parameter int unsigned HOLD = 4
) (
  input  wire logic pclk,
  output logic      go_o,
  output logic      halt_o,
  output logic      start_o,
  output logic      stop_o,
  output logic      loop_a_o,
  output logic      loop_b_o
);
  // contacts: 0 go, 1 halt, 2 port start, 3 port stop; high = closed
  logic [3:0] k_r = 4'h0;
  logic       lp_r = 1'b0;
  assign go_o     = k_r[0];
  assign halt_o   = k_r[1];
  assign start_o  = k_r[2];
  assign stop_o   = k_r[3];
  assign loop_a_o = lp_r;
  assign loop_b_o = lp_r;
  // closure held past the minimum, extra cycles model a slow hand
  task automatic press(input int i, input int extra);
    @(posedge pclk);
    k_r[i] <= 1'b1;
    repeat (HOLD + 12 + extra) @(posedge pclk);
    k_r[i] <= 1'b0;
  endtask : press
  task automatic loop(input logic c);
    @(posedge pclk);
    lp_r <= c;
  endtask : loop
endmodule : tssic_fixture
`default_nettype wire

// file: verif/tssic_ctrl_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module tssic_ctrl_asserts
  import tssic_pkg::*;
#(
  parameter int unsigned HOLD = tssic_pkg::HOLD_CYC
) (
  input wire logic       pclk,
  input wire logic       presetn,
  input wire logic       psel,
  input wire logic       penable,
  input wire logic       pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic       pready,
  input wire logic       pslverr,
  input wire logic       handheld_go_line,
  input wire logic       port_start_line,
  input wire logic       safety_loop_a,
  input wire logic       safety_loop_b,
  input wire logic       test_done,
  input wire logic       test_begin,
  input wire logic       test_abort,
  input wire logic [4:0] status_out
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [1:0]  src_r;
  logic        ilk_r;
  logic        run_r;
  logic [2:0]  cmd_r;
  int unsigned hh_r;
  int unsigned ps_r;
  int unsigned open_r;
  logic        wr;
  assign wr = psel && penable && pwrite;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      src_r <= 2'h0;
      ilk_r <= 1'b0;
    end else if (wr && paddr == OFS_CTRL) begin
      src_r <= pwdata[1:0];
      ilk_r <= pwdata[CTRL_ILK_BIT];
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) cmd_r <= 3'h0;
    else if (wr && paddr == OFS_CMD && pwdata[CMD_START_BIT]) cmd_r <= 3'h4;
    else if (cmd_r != 3'h0) cmd_r <= cmd_r - 3'h1;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) run_r <= 1'b0;
    else if (test_begin) run_r <= 1'b1;
    else if (test_abort || test_done) run_r <= 1'b0;
  end
  // saturating run lengths of closed contacts and of an open loop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hh_r <= 0;
      ps_r <= 0;
      open_r <= 0;
    end else begin
      hh_r <= !handheld_go_line ? 0 : (hh_r < HOLD + 64) ? hh_r + 1 : hh_r;
      ps_r <= !port_start_line ? 0 : (ps_r < HOLD + 64) ? ps_r + 1 : ps_r;
      open_r <= (safety_loop_a && safety_loop_b) ? 0 :
                (open_r < HOLD + 64) ? open_r + 1 : open_r;
    end
  end
  a_ready_high: assert property (pready)
    else $error("pready low");
  a_err_access: assert property (pslverr |-> psel && penable)
    else $error("pslverr outside access");
  a_begin_pulse: assert property (test_begin |=> !test_begin)
    else $error("test_begin longer than one cycle");
  a_one_event: assert property (!(test_begin && test_abort))
    else $error("begin and abort together");
  a_begin_source: assert property (test_begin |->
    (src_r == SRC_PANEL && cmd_r != 3'h0) ||
    (src_r == SRC_REMOTE && hh_r >= HOLD) ||
    (src_r == SRC_SIGIO && ps_r >= HOLD))
    else $error("start from unselected source");
  a_ilk_block: assert property (
    ilk_r && open_r > HOLD + 8 |-> !test_begin)
    else $error("start with open loop");
  a_panel_stop: assert property (
    wr && paddr == OFS_CMD && pwdata[CMD_STOP_BIT] && run_r
    |-> ##[1:3] test_abort)
    else $error("panel stop ignored");
  a_test_pin: assert property (
    test_begin |-> ##[1:3] status_out[1])
    else $error("test pin not raised");
  a_abort_pin: assert property (
    test_abort |-> ##[1:3] !status_out[1])
    else $error("test pin held after abort");
endmodule : tssic_ctrl_asserts
bind tssic_ctrl tssic_ctrl_asserts #(.HOLD(HOLD)) u_asserts (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
  .pslverr(pslverr), .handheld_go_line(handheld_go_line),
  .port_start_line(port_start_line), .safety_loop_a(safety_loop_a),
  .safety_loop_b(safety_loop_b), .test_done(test_done),
  .test_begin(test_begin), .test_abort(test_abort),
  .status_out(status_out));
`default_nettype wire

// file: verif/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import tssic_pkg::*;
  localparam int unsigned HOLD = 4;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 0;
  logic [31:0] pwdata = 0, rd;
  logic step_done = 0, test_done = 0, vp = 0, vh = 0, vl = 0, se;
  logic [2:0] tfn = 0;
  wire logic [31:0] prdata;
  wire logic pready, pslverr, test_begin, test_abort, hg, hs, ps, pp, la, lb;
  wire logic [4:0] st;
  int err_count = 0, tests_run = 0, nb = 0, na = 0, b0, a0;
  int i, k, n, v, f, tp, tt, ep[8], ef[8];
  tssic_ctrl #(.HOLD(HOLD)) u_tssic_ctrl (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .handheld_go_line(hg), .handheld_halt_line(hs), .port_start_line(ps),
    .port_stop_line(pp), .safety_loop_a(la), .safety_loop_b(lb),
    .step_done(step_done), .test_done(test_done), .verdict_pass(vp),
    .verdict_fail_hi(vh), .verdict_fail_lo(vl), .test_func(tfn),
    .test_begin(test_begin), .test_abort(test_abort), .status_out(st));
  tssic_fixture #(.HOLD(HOLD)) u_tssic_fixture (.pclk(pclk), .go_o(hg),
    .halt_o(hs), .start_o(ps), .stop_o(pp), .loop_a_o(la), .loop_b_o(lb));
  always #2.5 pclk = ~pclk;
  always @(negedge pclk) begin
    nb += (test_begin === 1'b1);
    na += (test_abort === 1'b1);
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      err_count++;
      $display("[FAIL] t=%0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    se = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [7:0] a, input int d);
    apb(1'b1, a, 32'(d));
  endtask : wr
  task automatic rdc(input logic [7:0] a, input int e);
    apb(1'b0, a, 32'h0);
    chk(rd, 32'(e));
  endtask : rdc
  task automatic press(input int c);
    u_tssic_fixture.press(c, $urandom % 8);
  endtask : press
  task automatic mark;
    b0 = nb;
    a0 = na;
  endtask : mark
  task automatic cnt(input int db, input int da);
    repeat (8) @(posedge pclk);
    chk(32'(nb - b0), 32'(db));
    chk(32'(na - a0), 32'(da));
  endtask : cnt
  function automatic int is_pass(input int vd);
    return (vd == 0) ? 1 : 0;
  endfunction : is_pass
  task automatic tst(input int vd, input int fn);
    @(posedge pclk);
    test_done <= 1'b1; vp <= (vd == 0); vh <= (vd == 1); vl <= (vd == 2);
    tfn <= fn[2:0];
    @(posedge pclk);
    test_done <= 1'b0;
  endtask : tst
  task automatic stp(input int vd);
    @(posedge pclk);
    step_done <= 1'b1; vp <= (vd == 0); vh <= (vd == 1); vl <= (vd == 2);
    @(posedge pclk);
    step_done <= 1'b0;
  endtask : stp
  task automatic pins(input int e);
    @(negedge pclk);
    chk(32'(st), 32'(e));
  endtask : pins
  // default pin map: ready, test, pass, fail, fail-high
  function automatic int exp_pins(input int vd);
    return 1 + ((vd == 0) ? 4 : 0) + ((vd != 0) ? 8 : 0) +
           ((vd == 1) ? 16 : 0);
  endfunction : exp_pins
  task automatic results;
    $display("mismatches %0d comparisons %0d", err_count, tests_run);
    if (err_count == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : results
  initial begin
    #100000;
    err_count++;
    results();
  end
  initial begin
    void'($urandom(32'h069d979b));
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    rdc(OFS_CTRL, 0);
    rdc(OFS_PINSEL, 32'h4688);
    rdc(OFS_STATUS, 1);
    apb(1'b0, 8'h28, 32'h0);
    chk(32'(se), 1);
    wr(OFS_CMD, 2);
    mark; wr(OFS_CMD, 3); cnt(0, 0);
    mark; press(0); cnt(0, 0);
    mark; press(2); cnt(0, 0);
    mark; wr(OFS_CMD, 1); cnt(1, 0);
    mark; wr(OFS_CMD, 2); cnt(0, 1);
    wr(OFS_CTRL, 1);
    wr(OFS_CMD, 2);
    mark; wr(OFS_CMD, 1); cnt(0, 0);
    mark; press(0); cnt(1, 0);
    mark; press(1); cnt(0, 1);
    wr(OFS_CTRL, 2);
    for (k = 0; k < 2; k++) begin
      press(3);
      rdc(OFS_STATUS, 2);
      mark; press(0); press(2); cnt(1, 0);
      mark;
      if (k == 1) wr(OFS_CMD, 2);
      else press(3);
      cnt(0, 1);
    end
    wr(OFS_CTRL, 6);
    press(3);
    mark; press(2); cnt(0, 0);
    rdc(OFS_STATUS, 32'h12);
    wr(OFS_CMD, 8);
    rdc(OFS_STATUS, 2);
    u_tssic_fixture.loop(1'b1);
    mark; press(2); cnt(1, 0);
    wr(OFS_CTRL, 0);
    n = 1 + $urandom % 6;
    for (i = 0; i < n; i++) begin
      v = $urandom % 3;
      f = (i == 0) ? 7 : $urandom % 8;
      wr(OFS_CMD, 2); wr(OFS_CMD, 1); tst(v, f);
      pins(32'h02);
      pins(exp_pins(v));
      tp += is_pass(v); tt++;
      if (is_pass(v) == 1) ep[f]++;
      else ef[f]++;
    end
    rdc(OFS_PASS, tp); rdc(OFS_FAIL, tt - tp); rdc(OFS_TOTAL, tt);
    for (i = 0; i < 8; i++) begin
      wr(OFS_FSEL, i);
      rdc(OFS_FPASS, ep[i]); rdc(OFS_FFAIL, ef[i]);
    end
    wr(OFS_CMD, 4);
    rdc(OFS_PASS, 0); rdc(OFS_FAIL, 0); rdc(OFS_TOTAL, 0);
    wr(OFS_CMD, 2); wr(OFS_CMD, 1); tst(0, 0);
    rdc(OFS_TOTAL, 1);
    wr(OFS_CTRL, 32'h18);
    wr(OFS_CMD, 1);
    stp(1);
    pins(32'h02);
    pins(32'h18);
    pins(32'h1a);
    tst(0, 0);
    pins(32'h1a);
    pins(32'h05);
    wr(OFS_PINSEL, 32'h18d);
    pins(32'h05);
    pins(32'h18);
    rdc(OFS_PINSEL, 32'h18d);
    wr(OFS_CMD, 1);
    tst(2, 0);
    pins(32'h02);
    pins(32'h19);
    results();
  end
endmodule : tb_top
`default_nettype wire
